// file: common/sbs_pkg.sv
// Shared constants and types for the sync burst SRAM control block
package sbs_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W      = 18;
    localparam int LANES       = 4;
    localparam int LANE_W      = 9;
    localparam int DATA_W      = LANES * LANE_W;
    localparam int BURST_W     = 2;
    localparam int BURST_POS   = 0;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] CNT_RST = 2'h0;

    // ----------------------------------------------------------------
    // Decoded command
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SBS_CMD_DESEL    = 3'b000,
        SBS_CMD_READ     = 3'b001,
        SBS_CMD_WRITE    = 3'b010,
        SBS_CMD_NEXT     = 3'b011,
        SBS_CMD_HOLD     = 3'b100
    } sbs_cmd_t;

    // Burst step, linear or interleaved
    function automatic logic [1:0] sbs_burst_addr(
        input logic [1:0] start,
        input logic [1:0] count,
        input logic       linear
    );
        logic [1:0] res;
        res = linear ? 2'(start + count) : (start ^ count);
        return res;
    endfunction

endpackage

// file: src/sbs_burst_counter.sv
// Two-bit burst counter with linear or interleaved order
`timescale 1ns/1ns
module sbs_burst_counter (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 load,
    input  wire logic                 advance,
    input  wire logic [1:0]           start,
    input  wire logic                 linear,
    output logic      [1:0]           burst_low
);
    import sbs_pkg::*;

    logic [1:0] start_reg;
    logic [1:0] count_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            start_reg <= CNT_RST;
        end else if (load) begin
            start_reg <= start;
        end
    end

    // R4: advance gated count
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_reg <= CNT_RST;
        end else if (load) begin
            count_reg <= CNT_RST;
        end else if (advance) begin
            count_reg <= 2'(count_reg + 2'h1);
        end
    end

    // R25: wrap within four
    always_comb begin
        burst_low = sbs_burst_addr(start_reg, count_reg, linear);
    end

endmodule

// file: src/sbs_sram_control.sv
// Command decode, write control and read pipeline of the burst SRAM
// ----------------------------------------------------------------
// Overview of operation
// R1: All synchronous inputs are sampled on the rising clock edge.
// R2: Output enable and sleep act combinationally, without a clock edge.
// R3: Either address strobe may start a burst from the external address.
// R4: Two-bit burst counter advances only when burst advance is asserted.
// R5: Burst order input selects linear or interleaved stepping.
// R6: Unconnected mode inputs default to interleaved, pipelined operation.
// R7: A new external address may be loaded on every cycle.
// R8: Deselect reaches outputs one stage earlier than read data.
// R9: Byte write writes lanes whose strobe is low; all high stores nothing.
// R10: Global write low writes every lane regardless of byte controls.
// R11: Both write controls high is a read driving all lanes.
// R12: Data lanes stay high impedance during every write.
// R13: Selected only when high select is 1 and both low selects 0.
// R14: Deselect, power down and float the bus on listed strobe cases.
// R15: Selected strobe conditions start a read burst at external address.
// R16: Selected load strobe with store flag starts a write burst.
// R17: Both strobes inactive and advance low steps to the next address.
// R18: Advance high repeats the access at the current burst address.
// R19: Output enable high kills drivers; low only enables pipeline drivers.
// R20: Controller may hold processor strobe high and load strobe low.
// R21: Controller may hold processor strobe high and advance low.
// R22: Sleep request or stopped clock keeps contents in low power.
// R23: A dummy read advances the burst counter like a normal read.
// R24: Read data appears one clock after the registered read command.
// R25: Burst counter changes only two low bits, wrapping within four.
// ----------------------------------------------------------------
`timescale 1ns/1ns
module sbs_sram_control #(
    parameter int ADDR_WIDTH = sbs_pkg::ADDR_W,
    parameter int NUM_LANES  = sbs_pkg::LANES,
    parameter int LANE_WIDTH = sbs_pkg::LANE_W
) (
    input  wire logic                              clk,
    input  wire logic                              sys_rst,
    input  wire logic [ADDR_WIDTH-1:0]             addr,
    input  wire logic [NUM_LANES*LANE_WIDTH-1:0]   data_in,
    output logic      [NUM_LANES*LANE_WIDTH-1:0]   data_out,
    output logic      [NUM_LANES-1:0]              data_oe,
    input  wire logic                              chip_select_low_first_n,
    input  wire logic                              chip_select_high_active,
    input  wire logic                              chip_select_low_third_n,
    input  wire logic                              processor_addr_strobe_n,
    input  wire logic                              load_strobe_ctrl_n,
    input  wire logic                              burst_advance_n,
    input  wire logic                              global_store_n,
    input  wire logic                              byte_lane_gate_n,
    input  wire logic [NUM_LANES-1:0]              per_lane_strobe_n,
    input  wire logic                              output_drive_enable_n,
    input  wire logic                              sleep_request,
    input  wire logic                              burst_order_select_n,
    output logic                                   sleep_active,
    output logic                                   power_down,
    output logic      [ADDR_WIDTH-1:0]             cur_addr
);
    import sbs_pkg::*;

    localparam int DW = NUM_LANES * LANE_WIDTH;

    // ----------------------------------------------------------------
    // Storage array
    // ----------------------------------------------------------------
    logic [DW-1:0] mem [0:(1<<ADDR_WIDTH)-1];

    // ----------------------------------------------------------------
    // Selection and write decode
    // ----------------------------------------------------------------
    logic                 selected;
    logic                 store_cycle;
    logic [NUM_LANES-1:0] lane_we;
    sbs_cmd_t             cmd;

    // R13: combined selection
    assign selected = chip_select_high_active & ~chip_select_low_first_n
                      & ~chip_select_low_third_n;

    // R9: per-lane byte write
    // R10: global write overrides
    // R11: both high is a read
    always_comb begin
        if (!global_store_n) begin
            lane_we     = '1;
            store_cycle = 1'b1;
        end else if (!byte_lane_gate_n) begin
            lane_we     = ~per_lane_strobe_n;
            store_cycle = 1'b1;
        end else begin
            lane_we     = '0;
            store_cycle = 1'b0;
        end
    end

    // R3: two start strobes
    // R14: deselect cases
    // R15: read burst start
    // R16: write burst start
    // R17: continue burst
    // R18: suspend burst
    always_comb begin
        if (!load_strobe_ctrl_n && !selected) begin
            cmd = SBS_CMD_DESEL;
        end else if (!processor_addr_strobe_n && !chip_select_low_first_n && !selected) begin
            cmd = SBS_CMD_DESEL;
        end else if (!processor_addr_strobe_n && selected) begin
            // Processor strobe ignores write controls
            cmd = SBS_CMD_READ;
        end else if (!load_strobe_ctrl_n) begin
            cmd = store_cycle ? SBS_CMD_WRITE : SBS_CMD_READ;
        end else if (!burst_advance_n) begin
            cmd = SBS_CMD_NEXT;
        end else begin
            cmd = SBS_CMD_HOLD;
        end
    end

    // ----------------------------------------------------------------
    // Burst address
    // ----------------------------------------------------------------
    logic                  load_addr;
    logic                  burst_advance;
    logic [ADDR_WIDTH-1:0] base_reg;
    logic                  write_burst_reg;
    logic [1:0]            burst_low;
    logic                  linear_sel;

    // R7: load every cycle allowed
    assign load_addr = (cmd == SBS_CMD_READ) || (cmd == SBS_CMD_WRITE);
    // R23: dummy reads count too
    assign burst_advance = (cmd == SBS_CMD_NEXT) && !sleep_request;
    // R5: order select
    // R6: low selects linear, high or pulled-up interleaved
    assign linear_sel = ~burst_order_select_n;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            base_reg <= '0;
        end else if (load_addr && !sleep_request) begin
            base_reg <= addr;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            write_burst_reg <= 1'b0;
        end else if (!sleep_request && cmd != SBS_CMD_DESEL) begin
            write_burst_reg <= (cmd == SBS_CMD_WRITE) ||
                               ((cmd == SBS_CMD_NEXT || cmd == SBS_CMD_HOLD) && store_cycle);
        end
    end

    sbs_burst_counter u_counter (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .load      (load_addr && !sleep_request),
        .advance   (burst_advance),
        .start     (addr[BURST_POS +: BURST_W]),
        .linear    (linear_sel),
        .burst_low (burst_low)
    );

    // R25: only low bits change
    always_comb begin
        cur_addr = base_reg;
        cur_addr[BURST_POS +: BURST_W] = burst_low;
    end

    // ----------------------------------------------------------------
    // Input register stage
    // ----------------------------------------------------------------
    logic                  acc_valid_reg;
    logic                  acc_write_reg;
    logic [NUM_LANES-1:0]  acc_we_reg;
    logic [ADDR_WIDTH-1:0] acc_addr_reg;
    logic [DW-1:0]         acc_data_reg;
    logic [ADDR_WIDTH-1:0] acc_addr;

    // Address used by this cycle: external on start, stepped or current otherwise
    always_comb begin
        acc_addr = load_addr ? addr : cur_addr;
        if (cmd == SBS_CMD_NEXT) begin
            acc_addr = next_addr(cur_addr);
        end
    end

    // R1: synchronous capture
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_valid_reg <= 1'b0;
            acc_write_reg <= 1'b0;
            acc_we_reg    <= '0;
            acc_addr_reg  <= '0;
            acc_data_reg  <= '0;
        end else if (!sleep_request) begin
            acc_valid_reg <= (cmd != SBS_CMD_DESEL);
            acc_write_reg <= (cmd == SBS_CMD_WRITE) ||
                             (cmd != SBS_CMD_READ && cmd != SBS_CMD_DESEL &&
                              store_cycle && write_burst_reg) ||
                             (cmd != SBS_CMD_READ && cmd != SBS_CMD_DESEL && store_cycle);
            acc_we_reg    <= (cmd == SBS_CMD_READ) ? '0 : lane_we;
            acc_addr_reg  <= acc_addr;
            acc_data_reg  <= data_in;
        end else begin
            acc_valid_reg <= 1'b0;
            acc_write_reg <= 1'b0;
            acc_we_reg    <= '0;
        end
    end

    function automatic logic [ADDR_WIDTH-1:0] next_addr(input logic [ADDR_WIDTH-1:0] a);
        logic [ADDR_WIDTH-1:0] r;
        logic [1:0]            cnt;
        r   = a;
        cnt = linear_sel ? 2'(burst_low - base_reg[BURST_POS +: BURST_W])
                         : (burst_low ^ base_reg[BURST_POS +: BURST_W]);
        r[BURST_POS +: BURST_W] = sbs_burst_addr(base_reg[BURST_POS +: BURST_W],
                                                 2'(cnt + 2'h1), linear_sel);
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Array access, self-timed write
    // ----------------------------------------------------------------
    // R22: array untouched in sleep
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_LANES; i++) begin
            if (acc_valid_reg && acc_write_reg && acc_we_reg[i] && !sleep_request) begin
                mem[acc_addr_reg][i*LANE_WIDTH +: LANE_WIDTH] <=
                    acc_data_reg[i*LANE_WIDTH +: LANE_WIDTH];
            end
        end
    end

    // ----------------------------------------------------------------
    // Output pipeline
    // ----------------------------------------------------------------
    logic drive_reg;

    // R24: data one clock later
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_out <= '0;
        end else if (acc_valid_reg && !acc_write_reg) begin
            data_out <= mem[acc_addr_reg];
        end
    end

    // R8: single-cycle deselect
    // R12: no drive on writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            drive_reg <= 1'b0;
        end else begin
            drive_reg <= acc_valid_reg && !acc_write_reg && !sleep_request &&
                         !(cmd == SBS_CMD_DESEL);
        end
    end

    // R2: asynchronous controls
    // R19: enable gates only active drivers
    always_comb begin
        data_oe = {NUM_LANES{drive_reg & ~output_drive_enable_n & ~sleep_request}};
    end

    assign sleep_active = sleep_request;
    assign power_down   = sleep_request | !acc_valid_reg;

endmodule

// file: verification/sbs_sram_assertions.sv
// Port-level checker for the burst SRAM control block
`timescale 1ns/1ns
module sbs_sram_assertions #(
    parameter int ADDR_WIDTH = 18,
    parameter int NUM_LANES  = 4
) (
    input wire logic                  clk,
    input wire logic                  sys_rst,
    input wire logic [ADDR_WIDTH-1:0] addr,
    input wire logic [NUM_LANES-1:0]  data_oe,
    input wire logic                  chip_select_low_first_n,
    input wire logic                  chip_select_high_active,
    input wire logic                  chip_select_low_third_n,
    input wire logic                  processor_addr_strobe_n,
    input wire logic                  load_strobe_ctrl_n,
    input wire logic                  burst_advance_n,
    input wire logic                  global_store_n,
    input wire logic                  byte_lane_gate_n,
    input wire logic                  output_drive_enable_n,
    input wire logic                  sleep_request,
    input wire logic                  burst_order_select_n,
    input wire logic                  sleep_active,
    input wire logic                  power_down,
    input wire logic [ADDR_WIDTH-1:0] cur_addr
);
    // ------------------------------------------------------------
    // Command decode seen from the pins
    // ------------------------------------------------------------
    logic                  sel, store, run, desel, rd_go, wr_go, cont;
    logic [ADDR_WIDTH-1:0] prev_addr;
    assign sel = chip_select_high_active && !chip_select_low_first_n
               && !chip_select_low_third_n;
    assign store = !global_store_n || !byte_lane_gate_n;
    assign run = !sleep_request;
    assign desel = run && !sel && (!load_strobe_ctrl_n
                 || (!processor_addr_strobe_n && !chip_select_low_first_n));
    assign rd_go = run && sel && (!processor_addr_strobe_n
                 || (!load_strobe_ctrl_n && !store));
    assign wr_go = run && sel && processor_addr_strobe_n && !load_strobe_ctrl_n && store;
    assign cont = run && load_strobe_ctrl_n
                && (processor_addr_strobe_n || chip_select_low_first_n);
    always_ff @(posedge clk) prev_addr <= cur_addr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Read whose data is not cut short by a deselect behind it
    sequence s_read;
        (rd_go || (cont && !store)) ##1 !desel;
    endsequence
    sequence s_write;
        wr_go || (cont && store);
    endsequence

    a_desel_float: assert property (desel |=> data_oe == '0 && power_down)
        else $error("deselect left lanes driven");
    a_read_drive: assert property (s_read |=>
        output_drive_enable_n || sleep_request || data_oe == '1)
        else $error("read data not driven");
    a_write_hiz: assert property (s_write |=> ##1 data_oe == '0)
        else $error("lanes driven during write");
    a_oe_off: assert property (output_drive_enable_n |-> data_oe == '0)
        else $error("output enable high but lanes driven");
    a_sleep_state: assert property (sleep_request |->
        sleep_active && power_down && data_oe == '0)
        else $error("sleep not entered at once");
    a_sleep_frozen: assert property (sleep_request |=> $stable(cur_addr))
        else $error("address moved in sleep");
    a_start_load: assert property (rd_go || wr_go |=> cur_addr == $past(addr))
        else $error("burst start address wrong");
    a_burst_hold: assert property (cont && burst_advance_n |=> $stable(cur_addr))
        else $error("suspended burst moved");
    a_linear_step: assert property (cont && !burst_advance_n && !burst_order_select_n
        |=> cur_addr == {prev_addr[ADDR_WIDTH-1:2], prev_addr[1:0] + 2'h1})
        else $error("linear burst step wrong");
endmodule

bind sbs_sram_control sbs_sram_assertions #(
    .ADDR_WIDTH(ADDR_WIDTH),
    .NUM_LANES (NUM_LANES)
) u_chk (.*);

// file: verification/sbs_host_model.sv
// Memory controller model driving the SRAM command and data pins
`timescale 1ns/1ns
module sbs_host_model (
    input  wire logic                  clk,
    output logic [sbs_pkg::ADDR_W-1:0] addr,
    output logic [sbs_pkg::DATA_W-1:0] data_in,
    output logic                       chip_select_low_first_n,
    output logic                       chip_select_high_active,
    output logic                       chip_select_low_third_n,
    output logic                       processor_addr_strobe_n,
    output logic                       load_strobe_ctrl_n,
    output logic                       burst_advance_n,
    output logic                       global_store_n,
    output logic                       byte_lane_gate_n,
    output logic [sbs_pkg::LANES-1:0]  per_lane_strobe_n,
    output logic                       output_drive_enable_n,
    output logic                       sleep_request,
    output logic                       burst_order_select_n
);
    import sbs_pkg::*;
    // ------------------------------------------------------------
    // One command per cycle, set up at the falling edge
    // ------------------------------------------------------------
    // any strobe mix held a cycle
    task automatic issue(input logic [2:0] cs, input logic [2:0] st, input logic [1:0] wr,
                         input logic [3:0] ln, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
        {chip_select_low_first_n, chip_select_high_active, chip_select_low_third_n} = cs;
        {processor_addr_strobe_n, load_strobe_ctrl_n, burst_advance_n} = st;
        {global_store_n, byte_lane_gate_n} = wr;
        per_lane_strobe_n = ln;
        addr = a;
        // Released bus inverts so stale data never looks valid
        data_in = (wr != 2'h3) ? d : ~data_in;
        @(negedge clk);
    endtask

    initial begin
        data_in = '0;
        output_drive_enable_n = 1'b0;
        sleep_request = 1'b0;
        // mode pin left at its idle level
        burst_order_select_n = 1'b1;
        issue(3'h4, 3'h5, 2'h3, 4'hf, '0, '0);
    end
endmodule

// file: verification/testbench.sv
// Self-checking bench for the burst SRAM control block
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
    $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module testbench;
    import sbs_pkg::*;
    localparam logic [2:0] SEL = 3'h2, OFF = 3'h4, PS = 3'h3, LD = 3'h5, NX = 3'h6, HD = 3'h7;
    localparam logic [1:0] RD = 2'h3, BW = 2'h2;
    localparam logic [ADDR_W-1:0] A0 = 18'h0_0040, A1 = 18'h3_ff83;
    localparam logic [DATA_W-1:0] D0 = 36'h1_2345_6789, D1 = 36'hf_edcb_a987;
    localparam logic [DATA_W-1:0] M = 36'hf_f803_fe00;
    logic              clk = 1'b0, sys_rst = 1'b1;
    logic [ADDR_W-1:0] addr, cur_addr;
    logic [DATA_W-1:0] data_in, data_out;
    logic [LANES-1:0]  data_oe, per_lane_strobe_n;
    logic              chip_select_low_first_n, chip_select_high_active, chip_select_low_third_n;
    logic              processor_addr_strobe_n, load_strobe_ctrl_n, burst_advance_n;
    logic              global_store_n, byte_lane_gate_n, output_drive_enable_n;
    logic              sleep_request, burst_order_select_n, sleep_active, power_down;
    int                mismatches = 0, checked = 0, cycles = 0;

    sbs_sram_control u_dut (.*);
    sbs_host_model u_host (.*);
    always #4 clk = ~clk;
    // Whole run needs under a hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            mismatches++;
            test_done;
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic wr(input logic [1:0] w, input logic [3:0] ln,
                      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        u_host.issue(SEL, LD, w, ln, a, d);
        `CHK(cur_addr, a)
        // Suspend cycle with all strobes high must store nothing
        u_host.issue(OFF, HD, BW, 4'hf, '0, '1);
        `CHK(data_oe, 4'h0)
    endtask

    task automatic t_writes;
        wr(2'h0, 4'hf, A0, D0);
        wr(2'h1, 4'ha, A1, D0);
        wr(BW, 4'h5, A1, D1);
        u_host.issue(SEL, PS, BW, 4'h0, A0, '0);
        u_host.issue(SEL, LD, RD, 4'hf, A1, '0);
        `CHK(data_out, D0)
        u_host.issue(OFF, HD, RD, 4'hf, '0, '0);
        `CHK(data_out, (D1 & M) | (D0 & ~M))
        `CHK(data_oe, 4'hf)
    endtask

    task automatic t_burst;
        logic [1:0] e;
        for (int m = 0; m < 2; m++) begin
            u_host.burst_order_select_n = m[0];
            u_host.output_drive_enable_n = m[0];
            u_host.issue(SEL, PS, RD, 4'hf, 18'h0_1235, '0);
            `CHK(cur_addr, 18'h0_1235)
            for (int c = 1; c < 4; c++) begin
                u_host.issue(OFF, NX, RD, 4'hf, '0, '0);
                e = m[0] ? 2'(1 ^ c) : 2'(1 + c);
                `CHK(cur_addr, {16'h048d, e})
                `CHK(data_oe, m[0] ? 4'h0 : 4'hf)
            end
            u_host.issue(OFF, HD, RD, 4'hf, '0, '0);
            `CHK(cur_addr, {16'h048d, e})
            u_host.issue(m[0] ? 3'h3 : 3'h0, m[0] ? PS : LD, RD, 4'hf, '0, '0);
            `CHK({power_down, data_oe}, 5'h10)
        end
        u_host.output_drive_enable_n = 1'b0;
    endtask

    task automatic t_sleep;
        u_host.sleep_request = 1'b1;
        #1;
        `CHK({sleep_active, power_down, data_oe}, 6'h30)
        @(negedge clk);
        u_host.issue(SEL, LD, 2'h0, 4'hf, A0, D1);
        u_host.sleep_request = 1'b0;
        u_host.issue(SEL, PS, RD, 4'hf, A0, '0);
        u_host.issue(OFF, HD, RD, 4'hf, '0, '0);
        `CHK(data_out, D0)
        `CHK({sleep_active, data_oe}, 5'h0f)
    endtask

    task automatic test_done;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        t_writes;
        t_burst;
        t_sleep;
        test_done;
    end
endmodule
